/* design/tmdsrx_cfg.svh */
`ifndef TMDSRX_CFG_SVH
`define TMDSRX_CFG_SVH

// Register byte offsets on the APB slave.
`define TRX_OFF_STATUS 12'h000
`define TRX_OFF_MASK   12'h004
`define TRX_OFF_STATE  12'h008

// Event bits shared by the status and mask registers.
`define TRX_EV_W    2
`define TRX_EV_LOST 0
`define TRX_EV_GAIN 1

// Bits of the read-only state register.
`define TRX_STATE_ACTIVE 0
`define TRX_STATE_PIXELS_PER_CLOCK_SELECT   1
`define TRX_STATE_STAGGER_SELECT_N_N 2
`define TRX_STATE_OE     3

// Reset value of the interrupt mask.
`define TRX_MASK_RST 2'h0

// Width of the activity counters.
`define TRX_CNT_W 20

// Layout of the synchronised pin vector.
`define TRX_IN_W     36
`define TRX_COMP_W   8
`define TRX_PIX_W    24
`define TRX_IN_LCLK  35
`define TRX_IN_DE    34
`define TRX_IN_RED   26
`define TRX_IN_GREEN 18
`define TRX_IN_BLUE  10
`define TRX_IN_RCTL  8
`define TRX_IN_GCTL  6
`define TRX_IN_BCTL  4
`define TRX_IN_STAGN 3
`define TRX_IN_PIXELS_PER_CLOCK_SELECT  2
`define TRX_IN_PDN   1
`define TRX_IN_PDON  0

// Control bit positions inside a lane's two-bit control field.
`define TRX_CTL_LO 0
`define TRX_CTL_HI 1

// Default pixel counts for losing and regaining the link.
`define TRX_LOST_PIX   1000000
`define TRX_RESUME_PIX 1600

`endif

/* design/tmdsrx_pkg.sv */
package tmdsrx_pkg;

	`include "tmdsrx_cfg.svh"

	// Which half of a two-pixel pair the next captured pixel fills.
	typedef enum logic {
		PH_EVEN,
		PH_ODD
	} tmdsrx_phase_e;

	// Activity counter type.
	typedef logic [`TRX_CNT_W-1:0] tmdsrx_cnt_t;

	// Complete state of the receiver output stage.
	typedef struct packed {
		logic [`TRX_IN_W-1:0]  sync1;      // First synchroniser stage.
		logic [`TRX_IN_W-1:0]  sync2;      // Second synchroniser stage.
		logic                  lclk_prev;  // Link clock level one cycle back.
		tmdsrx_phase_e         phase;      // Pair position.
		logic [`TRX_PIX_W-1:0] even_pend;  // Even pixel waiting for its partner.
		logic [`TRX_PIX_W-1:0] odd_pend;   // Odd pixel waiting for the staggered slot.
		logic                  odd_late;   // Staggered odd load due next cycle.
		logic [`TRX_PIX_W-1:0] even;       // Even pixel outputs.
		logic [`TRX_PIX_W-1:0] odd;        // Odd pixel outputs.
		logic                  hsync;      // Horizontal sync output.
		logic                  vsync;      // Vertical sync output.
		logic                  de;         // Data enable output.
		logic                  channel_one_control;       // Channel one control output.
		logic                  channel_two_control;       // Channel two control output.
		logic                  output_data_clock;       // Output data clock.
		logic                  oe;         // Output enable of the pixel port.
		logic                  de_last;    // Data enable at the previous pixel.
		tmdsrx_cnt_t           idle;       // Pixels since the last enable edge.
		tmdsrx_cnt_t           res;        // Pixels of renewed activity.
		logic                  active;     // Link active flag.
		logic [`TRX_EV_W-1:0]  status;     // Sticky event bits.
		logic [`TRX_EV_W-1:0]  mask;       // Interrupt mask.
		logic                  irq;        // Interrupt output.
		logic                  pready;     // APB ready.
		logic [31:0]           prdata;     // APB read data.
		logic                  pslverr;    // APB error.
	} tmdsrx_state_s;

endpackage : tmdsrx_pkg

/* design/tmdsrx_output_stage.sv */
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps
module tmdsrx_output_stage
	import tmdsrx_pkg::*;
#(
	parameter int LOST_PIX   = `TRX_LOST_PIX,
	parameter int RESUME_PIX = `TRX_RESUME_PIX
) (
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        link_reference_clock_i,
	input  wire logic        data_enable_i,
	input  wire logic [7:0]  red_data_lane_i,
	input  wire logic [7:0]  green_data_lane_i,
	input  wire logic [7:0]  blue_data_lane_i,
	input  wire logic [1:0]  red_lane_ctl_i,
	input  wire logic [1:0]  green_lane_ctl_i,
	input  wire logic [1:0]  blue_lane_ctl_i,
	input  wire logic        stagger_select_n_i,
	input  wire logic        pixels_per_clock_select_i,
	input  wire logic        global_power_down_n_i,
	input  wire logic        output_power_down_n_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             irq_o,
	output logic      [23:0] even_pixel_outputs_o,
	output logic      [23:0] odd_pixel_outputs_o,
	output logic             hsync_o,
	output logic             vsync_o,
	output logic             data_enable_o,
	output logic             channel_one_control_o,
	output logic             channel_two_control_o,
	output logic             output_data_clock_o,
	output logic             link_active_flag_o,
	output logic             outputs_oe_o
);

	// The counters must be able to hold both thresholds.
	initial begin
		if (LOST_PIX < 2 || LOST_PIX >= (1 << `TRX_CNT_W) || RESUME_PIX < 1 || RESUME_PIX >= LOST_PIX) begin
			$error("tmdsrx_output_stage: activity thresholds out of range");
		end
	end

	// Thresholds at counter width.
	localparam tmdsrx_cnt_t LOST_C   = tmdsrx_cnt_t'(LOST_PIX);
	localparam tmdsrx_cnt_t RESUME_C = tmdsrx_cnt_t'(RESUME_PIX);

	// Reset image: the link starts out idle, so no pixel counts as activity.
	localparam tmdsrx_state_s RST = '{
		phase:  PH_EVEN,
		idle:   LOST_C,
		mask:   `TRX_MASK_RST,
		default: '0
	};

	// Released reset copy used by everything below.
	logic [1:0]    rst_sync_q;  // Reset release synchroniser.
	logic          rst_n;       // Synchronised active-low reset.
	tmdsrx_state_s q;           // Registered state.
	tmdsrx_state_s d;           // Next state.

	// Decode of an APB byte address into {hit, index}; used for reads and writes.
	function automatic logic [2:0] reg_decode(input logic [11:0] addr);
		logic [2:0] r;
		r = 3'h0;
		case (addr)
			`TRX_OFF_STATUS: r = 3'h4;
			`TRX_OFF_MASK:   r = 3'h5;
			`TRX_OFF_STATE:  r = 3'h6;
			default:         r = 3'h0;
		endcase
		return r;
	endfunction : reg_decode

	// Reset is asserted at once and released two edges later.
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Every pin from the link or the board, packed for the synchroniser.
	logic [`TRX_IN_W-1:0] in_raw;
	assign in_raw = {link_reference_clock_i, data_enable_i, red_data_lane_i, green_data_lane_i,
		blue_data_lane_i, red_lane_ctl_i, green_lane_ctl_i, blue_lane_ctl_i, stagger_select_n_i,
		pixels_per_clock_select_i, global_power_down_n_i, output_power_down_n_i};

	// Synchronised views; only the second stage is read.
	logic                  lclk_s;   // Link clock level.
	logic                  rise;     // Rising link clock edge, one pixel.
	logic                  de_s;     // Incoming data enable.
	logic                  pix_s;    // Two-pixel mode.
	logic                  stagger_select_n_n_s; // Stagger select, active low.
	logic                  pd_n_s;   // Global power-down, active low.
	logic                  pdo_n_s;  // Output power-down, active low.
	logic [`TRX_PIX_W-1:0] pix_now;  // Pixel carried by the three lanes.
	logic                  tog;      // Data enable changed since last pixel.
	logic [2:0]            dec;      // Address decode result.
	logic                  access;   // APB access phase.
	logic [`TRX_EV_W-1:0]  ev;       // Events raised this cycle.
	logic [`TRX_EV_W-1:0]  clr;      // Status bits cleared by software.

	assign lclk_s   = q.sync2[`TRX_IN_LCLK];
	// The link clock period is the pixel time; each rising edge brings one pixel.
	assign rise     = lclk_s & ~q.lclk_prev;
	assign de_s     = q.sync2[`TRX_IN_DE];
	assign pix_s    = q.sync2[`TRX_IN_PIXELS_PER_CLOCK_SELECT];
	assign stagger_select_n_n_s = q.sync2[`TRX_IN_STAGN];
	assign pd_n_s   = q.sync2[`TRX_IN_PDN];
	assign pdo_n_s  = q.sync2[`TRX_IN_PDON];
	// During blanking the lanes carry control only, so the pixel reads as zero.
	assign pix_now  = de_s ? {q.sync2[`TRX_IN_RED +: `TRX_COMP_W], q.sync2[`TRX_IN_GREEN +: `TRX_COMP_W],
		q.sync2[`TRX_IN_BLUE +: `TRX_COMP_W]} : '0;
	assign tog      = de_s ^ q.de_last;
	assign dec      = reg_decode(paddr_i);
	assign access   = psel_i & penable_i;

	// Next-state logic for the whole block.
	always_comb begin
		d   = q;
		ev  = '0;
		clr = '0;
		d.sync1     = in_raw;
		d.sync2     = q.sync1;
		d.lclk_prev = lclk_s;
		d.odd_late  = 1'b0;
		d.pready    = 1'b0;

		// A staggered odd pixel lands one reference cycle after the even one.
		if (q.odd_late) begin
			d.odd = q.odd_pend;
		end

		// Either power-down pin releases the output port.
		d.oe = pd_n_s & pdo_n_s;

		// Output clock: follows the link in one-pixel mode, halves it in two-pixel mode.
		if (!pix_s) begin
			d.output_data_clock = lclk_s;
		end else if (rise) begin
			d.output_data_clock = ~q.output_data_clock;
		end

		if (rise) begin
			d.de_last = de_s;
			// Idle count restarts on every enable edge and saturates at the loss count.
			if (tog) begin
				d.idle = '0;
			end else if (q.idle != LOST_C) begin
				d.idle = q.idle + tmdsrx_cnt_t'(1);
			end
			if (q.active) begin
				// A silent enable for the full count marks the link inactive.
				if (d.idle == LOST_C) begin
					d.active = 1'b0;
					d.res    = '0;
					ev[`TRX_EV_LOST] = 1'b1;
				end
			end else begin
				// Renewed toggling must persist for the resume count.
				if (d.idle == LOST_C) begin
					d.res = '0;
				end else if (q.res == RESUME_C - tmdsrx_cnt_t'(1)) begin
					d.active = 1'b1;
					d.res    = '0;
					ev[`TRX_EV_GAIN] = 1'b1;
				end else begin
					d.res = q.res + tmdsrx_cnt_t'(1);
				end
			end

			// Pixel capture by mode.
			if (!pix_s) begin
				// One pixel per clock: even outputs carry every pixel.
				d.phase = PH_EVEN;
				d.even  = pix_now;
			end else if (q.phase == PH_EVEN) begin
				// First of a pair waits for its partner.
				d.even_pend = pix_now;
				d.phase     = PH_ODD;
			end else begin
				d.phase = PH_EVEN;
				d.even  = q.even_pend;
				if (stagger_select_n_n_s) begin
					d.odd = pix_now;
				end else begin
					d.odd_pend = pix_now;
					d.odd_late = 1'b1;
				end
			end
			// Control and sync follow the pixel that completes an output word.
			if (!pix_s || q.phase == PH_ODD) begin
				d.de    = de_s;
				d.hsync = q.sync2[`TRX_IN_BCTL + `TRX_CTL_LO];
				d.vsync = q.sync2[`TRX_IN_BCTL + `TRX_CTL_HI];
				d.channel_one_control  = q.sync2[`TRX_IN_GCTL + `TRX_CTL_LO];
				d.channel_two_control  = q.sync2[`TRX_IN_RCTL + `TRX_CTL_LO];
			end
		end

		// In one-pixel mode the odd bus is unused and forced low.
		if (!pix_s) begin
			d.odd      = '0;
			d.odd_late = 1'b0;
		end

		// APB: ready comes one cycle into the access phase, so each access takes two cycles.
		if (access && !q.pready) begin
			d.pready  = 1'b1;
			d.pslverr = ~dec[2];
			d.prdata  = 32'h0000_0000;
			// Decode on the full result so an unmapped address reads zero, not the status word.
			case (dec)
				3'h4:    d.prdata[`TRX_EV_W-1:0] = q.status;
				3'h5:    d.prdata[`TRX_EV_W-1:0] = q.mask;
				3'h6: begin
					d.prdata[`TRX_STATE_ACTIVE] = q.active;
					d.prdata[`TRX_STATE_PIXELS_PER_CLOCK_SELECT]   = pix_s;
					d.prdata[`TRX_STATE_STAGGER_SELECT_N_N] = stagger_select_n_n_s;
					d.prdata[`TRX_STATE_OE]     = q.oe;
				end
				default: d.prdata = 32'h0000_0000;
			endcase
		end
		// Writes take effect on the edge that completes the transfer.
		if (access && q.pready && pwrite_i && dec[2]) begin
			case (dec[1:0])
				2'h0:    clr    = pwdata_i[`TRX_EV_W-1:0];
				2'h1:    d.mask = pwdata_i[`TRX_EV_W-1:0];
				default: clr    = '0;
			endcase
		end

		// A new event outranks a simultaneous write-one clear.
		d.status = (q.status & ~clr) | ev;
		d.irq    = |(d.status & d.mask);
	end

	// Single register bank for the whole state.
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			q <= RST;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register; no output is tri-stated here, the flag included.
	assign prdata_o              = q.prdata;
	assign pready_o              = q.pready;
	assign pslverr_o             = q.pslverr;
	assign irq_o                 = q.irq;
	assign even_pixel_outputs_o  = q.even;
	assign odd_pixel_outputs_o   = q.odd;
	assign hsync_o               = q.hsync;
	assign vsync_o               = q.vsync;
	assign data_enable_o         = q.de;
	assign channel_one_control_o = q.channel_one_control;
	assign channel_two_control_o = q.channel_two_control;
	assign output_data_clock_o   = q.output_data_clock;
	assign link_active_flag_o    = q.active;
	assign outputs_oe_o          = q.oe;

	// Checks on the block's own behaviour.
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n);

	chk_odd_low_single: assert property ($past(!pix_s) |-> odd_pixel_outputs_o == '0)
		else $error("odd outputs not low in one-pixel mode");
	chk_oe_power_down: assert property ((!pd_n_s || !pdo_n_s) |=> !outputs_oe_o)
		else $error("outputs driven during power-down");
	chk_oe_power_up: assert property ((pd_n_s && pdo_n_s) |=> outputs_oe_o)
		else $error("outputs not driven while powered");
	chk_output_data_clock_single: assert property ((!pix_s && rise) |=> output_data_clock_o)
		else $error("output clock not high after pixel edge");
	chk_output_data_clock_double: assert property ((pix_s && rise) |=> output_data_clock_o != $past(output_data_clock_o))
		else $error("output clock did not toggle in two-pixel mode");
	chk_red_active: assert property ((rise && !pix_s && de_s) |=>
		even_pixel_outputs_o[23:16] == $past(q.sync2[`TRX_IN_RED +: `TRX_COMP_W]))
		else $error("red lane not on red outputs");
	chk_channel_two_control_blank: assert property ((rise && !pix_s && !de_s) |=>
		channel_two_control_o == $past(q.sync2[`TRX_IN_RCTL]) && even_pixel_outputs_o == '0)
		else $error("channel two control wrong in blanking");
	chk_sync_blank: assert property ((rise && !pix_s && !de_s) |=> hsync_o == $past(q.sync2[`TRX_IN_BCTL])
		&& channel_one_control_o == $past(q.sync2[`TRX_IN_GCTL]))
		else $error("sync or channel one control wrong");
	chk_stagger_offset: assert property ((rise && pix_s && q.phase == PH_ODD && !stagger_select_n_n_s) |=>
		(even_pixel_outputs_o == $past(q.even_pend)) ##1 (odd_pixel_outputs_o == $past(q.odd_pend)))
		else $error("staggered odd pixel not one cycle after even");
	chk_stagger_same: assert property ((rise && pix_s && q.phase == PH_ODD && stagger_select_n_n_s) |=>
		odd_pixel_outputs_o == $past(pix_now) && even_pixel_outputs_o == $past(q.even_pend))
		else $error("even and odd not updated together");
	chk_flag_fall: assert property ($fell(link_active_flag_o) |-> $past(q.idle) == LOST_C - tmdsrx_cnt_t'(1))
		else $error("link flag fell at wrong idle count");
	chk_flag_rise: assert property ($rose(link_active_flag_o) |-> $past(q.res) == RESUME_C - tmdsrx_cnt_t'(1))
		else $error("link flag rose at wrong resume count");
	chk_irq_level: assert property (irq_o == |(q.status & q.mask))
		else $error("interrupt does not match status and mask");

	cov_link_lost:   cover property ($fell(link_active_flag_o));
	cov_link_gained: cover property ($rose(link_active_flag_o));
	cov_stagger:     cover property (q.odd_late);
	cov_apb_write:   cover property (access && q.pready && pwrite_i);

endmodule : tmdsrx_output_stage

/* tb/tmdsrx_tx_model.sv */
`timescale 1ns/10ps
// Transmitter model: one pixel a link period, clock held low when nothing is queued.
module tmdsrx_tx_model (
	output logic       link_clk_o,
	output logic       de_o,
	output logic [7:0] red_o,
	output logic [7:0] green_o,
	output logic [7:0] blue_o,
	output logic [1:0] red_ctl_o,
	output logic [1:0] green_ctl_o,
	output logic [1:0] blue_ctl_o,
	output logic       busy_o
);
	logic [31:0] q[$];    // Queued words {de, channel_two_control, channel_one_control, vsync, hsync, rgb}.
	int          pending; // Queue depth as a plain count, visible to polling loops.
	logic [31:0] p;       // Word now on the lanes.

	// Appends one pixel word to the stream.
	task automatic push(input logic [31:0] w);
		q.push_back(w);
		pending++;
	endtask : push

	// Lanes change half a period from each rising edge so the sampler sees them settled.
	initial begin
		{link_clk_o, de_o, red_o, green_o, blue_o, red_ctl_o, green_ctl_o, blue_ctl_o, busy_o} = '0;
		pending = 0;
		#7;
		forever begin
			if (pending == 0) begin
				// Idle: clock stands still, stale data lanes are scrambled so nothing can lean on them.
				busy_o = 1'b0;
				{red_o, green_o, blue_o} = ~{red_o, green_o, blue_o};
				#200;
			end else begin
				busy_o = 1'b1;
				p = q.pop_front();
				pending--;
				de_o = p[28];
				red_ctl_o = {~red_ctl_o[1], p[27]};
				green_ctl_o = {~green_ctl_o[1], p[26]};
				blue_ctl_o = p[25:24];
				// Blanking carries no pixel, so the data lanes show garbage then.
				if (p[28]) begin
					{red_o, green_o, blue_o} = p[23:0];
				end else begin
					{red_o, green_o, blue_o} = ~{red_o, green_o, blue_o};
				end
				// Pixel time is the link period, stretched to 400 ns for the 20 MHz sampler.
				#200 link_clk_o = 1'b1;
				#200 link_clk_o = 1'b0;
			end
		end
	end
endmodule : tmdsrx_tx_model

/* tb/tb.sv */
`timescale 1ns/10ps
`include "tmdsrx_cfg.svh"
// Bench: link traffic from the model, registers over APB, a reference model checked at every pixel.
module tb import tmdsrx_pkg::*;;
	logic        ref_clk, resetn, stagger_select_n_n, pixels_per_clock_select, pdn, pdo_reg, route;
	logic        psel, penable, pwrite, pready, pslverr, irq, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        hs, vs, de_o, c1, c2, output_data_clock, flag, oe, lclk, de_l, busy, ph, ech;
	logic [23:0] even, odd, pe, po;
	logic [7:0]  r_l, g_l, b_l;
	logic [1:0]  rc_l, gc_l, bc_l;
	logic [31:0] a, lp;          // Held even pixel and pixel on the lanes.
	logic [23:0] e_even, e_odd;  // Expected pixel outputs.
	logic [4:0]  e_ctl;          // Expected {de, channel_two_control, channel_one_control, vsync, hsync}.
	logic [3:0]  last_ctl;       // Control bits of the latest blank pixel.
	int          fail_count, checks_done, cyc, sim_cnt, stagger_select_n_cnt, ock_cnt;
	int unsigned seed;

	// Reference clock, 20 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	tmdsrx_output_stage #(.LOST_PIX(40), .RESUME_PIX(8)) u_tmdsrx_output_stage (
		.ref_clk_i(ref_clk), .resetn_i(resetn), .link_reference_clock_i(lclk), .data_enable_i(de_l),
		.red_data_lane_i(r_l), .green_data_lane_i(g_l), .blue_data_lane_i(b_l),
		.red_lane_ctl_i(rc_l), .green_lane_ctl_i(gc_l), .blue_lane_ctl_i(bc_l),
		.stagger_select_n_i(stagger_select_n_n), .pixels_per_clock_select_i(pixels_per_clock_select), .global_power_down_n_i(pdn),
		.output_power_down_n_i(route ? flag : pdo_reg),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
		.even_pixel_outputs_o(even), .odd_pixel_outputs_o(odd), .hsync_o(hs), .vsync_o(vs),
		.data_enable_o(de_o), .channel_one_control_o(c1), .channel_two_control_o(c2),
		.output_data_clock_o(output_data_clock), .link_active_flag_o(flag), .outputs_oe_o(oe));

	tmdsrx_tx_model u_tmdsrx_tx_model (.link_clk_o(lclk), .de_o(de_l), .red_o(r_l), .green_o(g_l),
		.blue_o(b_l), .red_ctl_o(rc_l), .green_ctl_o(gc_l), .blue_ctl_o(bc_l), .busy_o(busy));

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the bench's hang guard ends a wait for the answer.
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Reads a register and compares data and error flag.
	task automatic rd_chk(input logic [11:0] ad, input logic [31:0] exp, input logic eerr);
		apb(1'b0, ad, 32'h0);
		chk(rd, exp);
		chk({31'h0, er}, {31'h0, eerr});
	endtask : rd_chk

	// Compares the pixel, sync, enable and control outputs with the reference model.
	task automatic cmp_all();
		chk({8'h0, even}, {8'h0, e_even});
		chk({8'h0, odd}, {8'h0, e_odd});
		chk({27'h0, de_o, c2, c1, vs, hs}, {27'h0, e_ctl});
	endtask : cmp_all

	// Queues n pixels, waits for the burst to drain, then checks the last result.
	task automatic send(input int n, input bit blank);
		logic [31:0] w;
		logic        d;
		for (int i = 0; i < n; i++) begin
			d = !blank && (i % 5 != 4);
			if (!d) last_ctl = 4'($urandom);
			w = {3'h0, d, last_ctl, 24'($urandom)};
			u_tmdsrx_tx_model.push(w);
		end
		repeat (10) @(posedge ref_clk);
		while (busy) @(posedge ref_clk);
		repeat (10) @(posedge ref_clk);
		cmp_all();
	endtask : send

	// Reference model: each rising link edge checks the last result, then takes the pixel on the lanes.
	always @(posedge lclk) begin
		cmp_all();
		lp = {3'h0, de_l, rc_l[0], gc_l[0], bc_l[1], bc_l[0], r_l, g_l, b_l};
		if (!pixels_per_clock_select) begin
			e_even = lp[28] ? lp[23:0] : 24'h0;
			e_odd  = 24'h0;
			e_ctl  = lp[28:24];
		end else if (!ph) begin
			a  = lp;
			ph = 1'b1;
		end else begin
			e_even = a[28] ? a[23:0] : 24'h0;
			e_odd  = lp[28] ? lp[23:0] : 24'h0;
			e_ctl  = lp[28:24];
			ph     = 1'b0;
		end
	end

	// Notes whether even and odd outputs move on one edge or odd trails by one.
	always @(posedge ref_clk) begin
		if (even !== pe && odd !== po) sim_cnt++;
		if (odd !== po && ech) stagger_select_n_cnt++;
		ech <= (even !== pe);
		pe  <= even;
		po  <= odd;
	end

	// Counts rising edges of the output data clock.
	always @(posedge output_data_clock) ock_cnt++;

	// Hang guard, far above the thousand or so cycles the sequence needs.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			close_out();
		end
	end

	// Main sequence.
	initial begin
		{resetn, pixels_per_clock_select, route, psel, penable, pwrite, paddr, pwdata, ph, ech, pe, po} = '0;
		{stagger_select_n_n, pdn, pdo_reg} = 3'b111;
		{e_even, e_odd, e_ctl, last_ctl, a} = '0;
		{fail_count, checks_done, cyc, sim_cnt, stagger_select_n_cnt, ock_cnt} = '0;
		seed = $urandom(32'h03ed);
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk({31'h0, oe}, 32'h1);
		rd_chk(`TRX_OFF_STATUS, 32'h0, 1'b0);
		rd_chk(`TRX_OFF_MASK, 32'h0, 1'b0);
		rd_chk(`TRX_OFF_STATE, 32'hc, 1'b0);
		apb(1'b1, `TRX_OFF_MASK, 32'hffffffff);
		rd_chk(`TRX_OFF_MASK, 32'h3, 1'b0);
		apb(1'b1, `TRX_OFF_STATE, 32'h0);
		rd_chk(`TRX_OFF_STATE, 32'hc, 1'b0);
		rd_chk(12'h00c, 32'h0, 1'b1);
		apb(1'b1, 12'h00c, 32'h1);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, `TRX_OFF_MASK, 32'h2);
		// One pixel per clock, enable toggling: flag rises and the gain event interrupts.
		ock_cnt = 0;
		send(24, 1'b0);
		chk(32'(ock_cnt), 32'd24);
		chk({31'h0, flag}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		rd_chk(`TRX_OFF_STATUS, 32'h2, 1'b0);
		apb(1'b1, `TRX_OFF_STATUS, 32'h2);
		rd_chk(`TRX_OFF_STATUS, 32'h0, 1'b0);
		chk({31'h0, irq}, 32'h0);
		// Two pixels per clock: simultaneous, then staggered.
		for (int s = 1; s >= 0; s--) begin
			stagger_select_n_n <= s[0];
			pixels_per_clock_select <= 1'b1;
			ph = 1'b0;
			repeat (6) @(posedge ref_clk);
			{sim_cnt, stagger_select_n_cnt, ock_cnt} = '0;
			send(16, 1'b0);
			chk(32'(ock_cnt), 32'd8);
			chk({31'h0, s[0] ? sim_cnt > 0 : stagger_select_n_cnt > 0}, 32'h1);
			chk(32'(s[0] ? stagger_select_n_cnt : sim_cnt), 32'h0);
		end
		// Enable stops toggling: flag falls, routed power-down kills the outputs, masked event stays quiet.
		route <= 1'b1;
		send(48, 1'b1);
		chk({31'h0, flag}, 32'h0);
		chk({31'h0, oe}, 32'h0);
		rd_chk(`TRX_OFF_STATUS, 32'h1, 1'b0);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `TRX_OFF_MASK, 32'h3);
		rd_chk(`TRX_OFF_STATE, 32'h2, 1'b0);
		chk({31'h0, irq}, 32'h1);
		route <= 1'b0;
		apb(1'b1, `TRX_OFF_STATUS, 32'h1);
		repeat (6) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		chk({31'h0, oe}, 32'h1);
		// Each power-down pin alone takes the outputs off.
		pdn <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk({31'h0, oe}, 32'h0);
		pdn <= 1'b1;
		pdo_reg <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk({31'h0, oe}, 32'h0);
		close_out();
	end
endmodule : tb
